// File: autoneg_regs_pkg.sv
// Package: register map, field positions and reset values of the negotiation register bank
package autoneg_regs_pkg;
    localparam logic [15:0] MGMT_DEVICE = 16'h0007;
    localparam logic [15:0] STATUS_INDEX = 16'h0201;
    localparam logic [15:0] ADVERT_INDEX = 16'h0202;
    localparam logic [15:0] CONTROL_INDEX = 16'h0200;
    localparam logic [15:0] ROLE_INDEX = 16'h0203;
    localparam logic [15:0] STATUS_RESET = 16'h0008;
    localparam logic [15:0] ADVERT_RESET = 16'h0001;
    localparam logic [15:0] CONTROL_RESET = 16'h1000;
    localparam logic [15:0] ROLE_RESET = 16'h0000;
    localparam int ST_PAGE_BIT = 6;
    localparam int ST_DONE_BIT = 5;
    localparam int ST_FAULT_BIT = 4;
    localparam int ST_CAPABLE_BIT = 3;
    localparam int ST_LINK_BIT = 2;
    localparam int AD_NEXT_PAGE_BIT = 15;
    localparam int AD_ACK_BIT = 14;
    localparam int AD_FAULT_BIT = 13;
    localparam int AD_FORCE_BIT = 12;
    localparam int AD_PAUSE_HI = 11;
    localparam int AD_PAUSE_LO = 10;
    localparam int CT_ENABLE_BIT = 12;
    localparam int RL_ROLE_BIT = 4;
    localparam logic [4:0] SELECTOR_VALUE = 5'h01;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// File: autoneg_status_advert_regs.sv
// Negotiation status and local advertisement register bank with a Wishbone slave
//
// Summary of operation
// R1: Capture of a partner codeword sets the page received flag.
// R2: Page received flag holds high and clears on any status read.
// R3: Software trusts partner ability registers after first page received.
// R4: Done reads one only when finished, link up and abilities valid.
// R5: Done reads zero while negotiation enable is cleared.
// R6: Partner fault flag latches on base page fault indication until read.
// R7: Negotiation capable bit is read-only and reads one.
// R8: Link up reads one while linked; failure latches zero until read.
// R9: Status register at 0x0201, reset 0x0008, reserved bits read zero.
// R10: Writable next page request is advertised; resets to zero.
// R11: Read-only acknowledge is set when partner codeword is received.
// R12: Writable advertised fault, reset zero, sent as base page fault.
// R13: Force role zero makes the advertised role a preference.
// R14: Force role one makes the advertised role mandatory.
// R15: Writable two-bit pause ability field, resetting to zero.
// R16: Selector field is read-only and always holds the Ethernet selector.
// R17: Advertisement register at 0x0202, reset 0x0001, bits 9..5 zero.
// R18: Negotiation enable is control bit 12 and resets to one.
// R19: Preferred role bit 4: zero slave, one master, qualified by force.
// R20: Writes to read-only or reserved bits are ignored, clear nothing.
// R21: Latched flags capture and clear atomically; events in the read survive.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module autoneg_status_advert_regs
    import autoneg_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic page_captured,
    input wire logic base_page_fault,
    input wire logic codeword_received,
    input wire logic negotiation_finished,
    input wire logic ability_valid,
    input wire logic link_ok,
    output logic next_page_request,
    output logic advertised_fault,
    output logic force_role,
    output logic preferred_role,
    output logic [1:0] pause_ability,
    output logic negotiation_enable,
    output logic role_mandatory
);
    typedef struct packed {
        logic [31:0] rdata;
        logic ack;
        logic page_received_flag;
        logic partner_fault_flag;
        logic link_up_latched;
        logic codeword_acknowledge;
        logic next_page_request;
        logic advertised_fault;
        logic force_role;
        logic [1:0] pause_ability;
        logic negotiation_enable;
        logic preferred_role;
        logic [2:0] page_s;
        logic [2:0] fault_s;
        logic [1:0] ack_s;
        logic [1:0] fin_s;
        logic [1:0] valid_s;
        logic [1:0] link_s;
    } state_s;

    state_s q;
    state_s next_q;

    // Word index within the management device; byte address is four times it
    function automatic logic [15:0] word_index(input logic [17:0] adr);
        return adr[17:2];
    endfunction

    logic req;
    logic rd_hit_status;
    logic wr_en;
    logic page_evt;
    logic fault_evt;
    logic link_now;
    logic done_now;
    logic [15:0] status_word;
    logic [15:0] advert_word;
    logic rd_hit_advert;
    logic wr_hit_advert;
    logic wr_hit_status;
    logic wr_hit_control;
    logic wr_hit_role;

    assign req = wb_cyc_i && wb_stb_i && !q.ack;
    assign rd_hit_status = req && !wb_we_i && word_index(wb_adr_i) == STATUS_INDEX;
    assign wr_en = req && wb_we_i;
    // Per-register decodes; the assertions below lean on these
    assign rd_hit_advert = req && !wb_we_i && word_index(wb_adr_i) == ADVERT_INDEX;
    assign wr_hit_advert = wr_en && wb_sel_i[1] && word_index(wb_adr_i) == ADVERT_INDEX;
    assign wr_hit_status = wr_en && word_index(wb_adr_i) == STATUS_INDEX;
    assign wr_hit_control = wr_en && wb_sel_i[1] && word_index(wb_adr_i) == CONTROL_INDEX;
    assign wr_hit_role = wr_en && wb_sel_i[0] && word_index(wb_adr_i) == ROLE_INDEX;
    // Synchronised inputs from the negotiation engine; page and fault edge detected after stage two
    assign page_evt = q.page_s[1] && !q.page_s[2];
    assign fault_evt = q.fault_s[1] && !q.fault_s[2];
    assign link_now = q.link_s[1];
    assign done_now = q.negotiation_enable && q.fin_s[1] && link_now && q.valid_s[1]; // [R4] [R5]

    always_comb begin
        status_word = 16'h0000; // [R9]
        status_word[ST_PAGE_BIT] = q.page_received_flag;
        status_word[ST_DONE_BIT] = done_now;
        status_word[ST_FAULT_BIT] = q.partner_fault_flag;
        status_word[ST_CAPABLE_BIT] = 1'b1; // [R7]
        status_word[ST_LINK_BIT] = q.link_up_latched;
        advert_word = 16'h0000; // [R17]
        advert_word[AD_NEXT_PAGE_BIT] = q.next_page_request;
        advert_word[AD_ACK_BIT] = q.codeword_acknowledge;
        advert_word[AD_FAULT_BIT] = q.advertised_fault;
        advert_word[AD_FORCE_BIT] = q.force_role;
        advert_word[AD_PAUSE_HI:AD_PAUSE_LO] = q.pause_ability;
        advert_word[4:0] = SELECTOR_VALUE; // [R16]
    end

    always_comb begin
        next_q = q;
        next_q.page_s = {q.page_s[1:0], page_captured};
        next_q.fault_s = {q.fault_s[1:0], base_page_fault};
        // Two sync stages, then the acknowledge register itself
        next_q.ack_s = {q.ack_s[0], codeword_received};
        next_q.fin_s = {q.fin_s[0], negotiation_finished};
        next_q.valid_s = {q.valid_s[0], ability_valid};
        next_q.link_s = {q.link_s[0], link_ok};
        next_q.codeword_acknowledge = q.ack_s[1]; // [R11]
        next_q.ack = req;
        if (req && !wb_we_i) begin
            unique case (word_index(wb_adr_i))
                STATUS_INDEX: next_q.rdata = {16'h0000, status_word};
                ADVERT_INDEX: next_q.rdata = {16'h0000, advert_word};
                CONTROL_INDEX: next_q.rdata = {19'h00000, q.negotiation_enable, 12'h000};
                ROLE_INDEX: next_q.rdata = {27'h0000000, q.preferred_role, 4'h0};
                default: next_q.rdata = UNMAPPED_DATA;
            endcase
        end
        // Read clears first, then fresh events set, so nothing arriving now is lost
        if (rd_hit_status) begin
            next_q.page_received_flag = 1'b0; // [R2] [R21]
            next_q.partner_fault_flag = 1'b0; // [R21]
            next_q.link_up_latched = link_now; // [R8] [R21]
        end
        if (page_evt) begin
            next_q.page_received_flag = 1'b1; // [R1]
        end
        if (fault_evt) begin
            next_q.partner_fault_flag = 1'b1; // [R6]
        end
        if (!link_now) begin
            next_q.link_up_latched = 1'b0; // [R8]
        end
        // Only writable fields follow the bus; status writes change nothing
        if (wr_en && wb_sel_i[1]) begin
            if (word_index(wb_adr_i) == ADVERT_INDEX) begin
                next_q.next_page_request = wb_dat_i[AD_NEXT_PAGE_BIT]; // [R10] [R20]
                next_q.advertised_fault = wb_dat_i[AD_FAULT_BIT]; // [R12]
                next_q.force_role = wb_dat_i[AD_FORCE_BIT]; // [R13] [R14]
                next_q.pause_ability = wb_dat_i[AD_PAUSE_HI:AD_PAUSE_LO]; // [R15]
            end
            if (word_index(wb_adr_i) == CONTROL_INDEX) begin
                next_q.negotiation_enable = wb_dat_i[CT_ENABLE_BIT]; // [R18]
            end
        end
        if (wr_en && wb_sel_i[0] && word_index(wb_adr_i) == ROLE_INDEX) begin
            next_q.preferred_role = wb_dat_i[RL_ROLE_BIT]; // [R19]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.link_up_latched <= STATUS_RESET[ST_LINK_BIT];
            q.next_page_request <= ADVERT_RESET[AD_NEXT_PAGE_BIT];
            q.advertised_fault <= ADVERT_RESET[AD_FAULT_BIT];
            q.force_role <= ADVERT_RESET[AD_FORCE_BIT];
            q.pause_ability <= ADVERT_RESET[AD_PAUSE_HI:AD_PAUSE_LO];
            q.negotiation_enable <= CONTROL_RESET[CT_ENABLE_BIT];
            q.preferred_role <= ROLE_RESET[RL_ROLE_BIT];
        end else begin
            q <= next_q;
        end
    end

    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign next_page_request = q.next_page_request;
    assign advertised_fault = q.advertised_fault;
    assign force_role = q.force_role;
    assign preferred_role = q.preferred_role;
    assign pause_ability = q.pause_ability;
    assign negotiation_enable = q.negotiation_enable;
    // Role is binding only when forced; otherwise resolution may override it
    assign role_mandatory = q.force_role; // [R13] [R14]

    sequence status_read_s;
        rd_hit_status && !page_evt;
    endsequence

    sequence page_event_s;
        page_evt;
    endsequence

    sequence status_answer_s;
        wb_ack_o && $past(rd_hit_status);
    endsequence

    sequence advert_read_s;
        wb_ack_o && $past(rd_hit_advert);
    endsequence

    sequence advert_write_s;
        wr_hit_advert;
    endsequence

    sequence control_write_s;
        wr_hit_control;
    endsequence

    sequence role_write_s;
        wr_hit_role;
    endsequence

    sequence status_write_s;
        wr_hit_status && q.page_received_flag;
    endsequence

    AST_PAGE_SET: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        page_event_s |=> q.page_received_flag) else $error("page flag not set");
    AST_PAGE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        status_read_s |=> !q.page_received_flag) else $error("page flag not cleared");
    AST_DONE_GATED: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (wb_ack_o && $past(rd_hit_status) && wb_dat_o[ST_DONE_BIT]) |->
        $past(q.fin_s[1] && q.link_s[1] && q.valid_s[1])) else $error("done without cause");
    AST_DONE_DISABLED: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        (wb_ack_o && $past(rd_hit_status) && !$past(q.negotiation_enable))
        |-> !wb_dat_o[ST_DONE_BIT]) else $error("done while disabled");
    AST_FAULT_SET: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        fault_evt |=> q.partner_fault_flag) else $error("fault flag not set");
    AST_CAPABLE: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        (wb_ack_o && $past(rd_hit_status)) |-> wb_dat_o[ST_CAPABLE_BIT])
        else $error("capable bit low");
    AST_LINK_LOW: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        (!link_now && !rd_hit_status) ##1 !rd_hit_status |=> !q.link_up_latched)
        else $error("link failure not latched");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        (wb_ack_o && $past(rd_hit_status)) |-> (wb_dat_o[15:7] == 9'h000 && wb_dat_o[1:0] == 2'h0))
        else $error("status reserved bits set");
    AST_SELECTOR: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        advert_read_s |-> wb_dat_o[4:0] == SELECTOR_VALUE)
        else $error("selector wrong");
    AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_n) // Wishbone acknowledge is a one-cycle pulse
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

    // Further checks; the write checks compare against the data lanes of the accepted cycle
    AST_DONE_SET: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (wb_ack_o && $past(rd_hit_status && q.negotiation_enable && q.fin_s[1]
        && q.link_s[1] && q.valid_s[1])) |-> wb_dat_o[ST_DONE_BIT])
        else $error("done missing");
    AST_FAULT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        (rd_hit_status && !fault_evt) |=> !q.partner_fault_flag)
        else $error("fault flag not cleared");
    AST_LINK_RELOAD: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        (rd_hit_status && link_now) |=> q.link_up_latched)
        else $error("link latch not reloaded");
    AST_NEXT_PAGE_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        advert_write_s |=> next_page_request == $past(wb_dat_i[AD_NEXT_PAGE_BIT]))
        else $error("next page request not written");
    AST_ACK_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        q.ack_s[1] |=> q.codeword_acknowledge)
        else $error("acknowledge not set");
    AST_FAULT_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        advert_write_s |=> advertised_fault == $past(wb_dat_i[AD_FAULT_BIT]))
        else $error("advertised fault not written");
    AST_FORCE_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R13] [R14]
        advert_write_s |=> role_mandatory == $past(wb_dat_i[AD_FORCE_BIT]))
        else $error("force role not written");
    AST_PAUSE_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        advert_write_s |=> pause_ability == $past(wb_dat_i[AD_PAUSE_HI:AD_PAUSE_LO]))
        else $error("pause ability not written");
    AST_ADVERT_RESERVED: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        advert_read_s |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[9:5] == 5'h00)
        else $error("advert reserved bits set");
    AST_ENABLE_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        control_write_s |=> negotiation_enable == $past(wb_dat_i[CT_ENABLE_BIT]))
        else $error("enable not written");
    AST_ROLE_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
        role_write_s |=> preferred_role == $past(wb_dat_i[RL_ROLE_BIT]))
        else $error("preferred role not written");
    AST_RO_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
        status_write_s |=> q.page_received_flag)
        else $error("status write cleared a flag");
    AST_READ_ATOMIC: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
        status_answer_s |-> wb_dat_o[ST_PAGE_BIT] == $past(q.page_received_flag)
        && wb_dat_o[ST_FAULT_BIT] == $past(q.partner_fault_flag))
        else $error("read not atomic with clear");
endmodule // autoneg_status_advert_regs

// File: link_partner_model.sv
// Remote link partner: codeword capture, fault and link levels
`timescale 1ns/1ps
module link_partner_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send_page,
    input wire logic send_fault,
    input wire logic linked,
    output logic page_captured,
    output logic base_page_fault,
    output logic codeword_received,
    output logic negotiation_finished,
    output logic ability_valid,
    output logic link_ok
);
    logic [2:0] hold;
    logic got;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 3'h0;
            got <= 1'b0;
        end else if (send_page) begin
            hold <= 3'h6;
            got <= 1'b1;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    // Held six cycles so the two-stage synchroniser cannot miss it
    assign page_captured = (hold != 3'h0);
    assign base_page_fault = page_captured & send_fault;
    assign codeword_received = got;
    // Abilities count as valid once the first page is
    assign negotiation_finished = got & linked;
    assign ability_valid = got;
    assign link_ok = linked;
endmodule // link_partner_model

// File: tb.sv
// Testbench for the negotiation status and advertisement register bank
`timescale 1ns/1ps
module tb;
    import autoneg_regs_pkg::*;
    logic clk, rst_n, cyc, stb, we, ack, send_page, send_fault, linked;
    logic pc, bf, cr, nf, av, lk, np, af, fr, pr, en, rm;
    logic [17:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, d;
    logic [1:0] pa;
    int num_errors = 0;
    int check_count = 0;
    autoneg_status_advert_regs DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .page_captured(pc), .base_page_fault(bf),
        .codeword_received(cr), .negotiation_finished(nf), .ability_valid(av),
        .link_ok(lk), .next_page_request(np), .advertised_fault(af), .force_role(fr),
        .preferred_role(pr), .pause_ability(pa), .negotiation_enable(en),
        .role_mandatory(rm));
    link_partner_model partner (.clk(clk), .rst_n(rst_n), .send_page(send_page),
        .send_fault(send_fault), .linked(linked), .page_captured(pc),
        .base_page_fault(bf), .codeword_received(cr), .negotiation_finished(nf),
        .ability_valid(av), .link_ok(lk));
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Request held until the rising edge that samples ack; data taken there
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] v);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(d, e);
    endtask
    task automatic page(input logic f);
        @(posedge clk);
        send_fault <= f;
        send_page <= 1'b1;
        @(posedge clk);
        send_page <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    function automatic logic [31:0] outs();
        return {24'h0, np, af, fr, rm, pa, pr, en};
    endfunction
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
    initial begin
        {rst_n, cyc, stb, we, send_page, send_fault, linked} = 7'h0;
        adr = 18'h0;
        sel = 4'hf;
        wdat = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(18'h00804, {16'h0, STATUS_RESET});
        rd(18'h00808, {16'h0, ADVERT_RESET});
        rd(18'h00800, {16'h0, CONTROL_RESET});
        rd(18'h00ffc, UNMAPPED_DATA);
        chk(outs(), 32'h01);
        $display("test reset values done");
        xfer(1'b1, 18'h00808, 32'h0000ffff);
        rd(18'h00808, 32'h0000bc01);
        chk(outs(), 32'hfd);
        xfer(1'b1, 18'h00808, 32'h0);
        chk(outs(), 32'h01);
        xfer(1'b1, 18'h0080c, 32'h10);
        chk(outs(), 32'h03);
        $display("test advertisement done");
        linked <= 1'b1;
        repeat (8) @(posedge clk);
        xfer(1'b0, 18'h00804, 32'h0);
        page(1'b1);
        rd(18'h00804, 32'h0000007c);
        rd(18'h00808, 32'h00004001);
        rd(18'h00804, 32'h0000002c);
        $display("test page reception done");
        xfer(1'b1, 18'h00800, 32'h0);
        chk(outs(), 32'h02);
        rd(18'h00804, 32'h0000000c);
        xfer(1'b1, 18'h00800, 32'h1000);
        linked <= 1'b0;
        repeat (8) @(posedge clk);
        linked <= 1'b1;
        repeat (8) @(posedge clk);
        rd(18'h00804, 32'h00000028);
        rd(18'h00804, 32'h0000002c);
        $display("test enable and link loss done");
        page(1'b0);
        xfer(1'b1, 18'h00804, 32'h0000ffff);
        rd(18'h00804, 32'h0000006c);
        $display("test read-only writes done");
        sel <= 4'h1;
        xfer(1'b1, 18'h00808, 32'h0000ff00);
        sel <= 4'hf;
        rd(18'h00808, 32'h00004001);
        $display("test byte lanes done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(18'h00804, {16'h0, STATUS_RESET});
        rd(18'h00808, {16'h0, ADVERT_RESET});
        chk(outs(), 32'h01);
        $display("test mid-run reset done");
        close_out();
    end
endmodule // tb
